/* crp_params.svh */
`ifndef CRP_PARAMS_SVH
`define CRP_PARAMS_SVH

// Register addresses
`define CRP_ADDR_GEN_CFG 7'h00
`define CRP_ADDR_REF_CFG 7'h01
`define CRP_ADDR_MODE 7'h20
`define CRP_ADDR_ACTUAL 7'h21
`define CRP_ADDR_STATUS 7'h22
`define CRP_ADDR_SPAN 7'h36
`define CRP_ADDR_TARGET 7'h37
`define CRP_ADDR_EXT 7'h7C

// Field positions
`define CRP_GEN_SHOW_REVS 0
`define CRP_REF_ZERO_ARR 0
`define CRP_REF_CIRC 1
`define CRP_MODE_POS 2
`define CRP_EXT_INT 31

// Reset values, timing and extension check values
`define CRP_RST_WORD 32'h0000_0000
`define CRP_STEP_DIV 4
`define CRP_EXT_ONE 32'h8000_0000
`define CRP_EXT_HALF 32'h4000_0000
`define CRP_EXT_FIVE_QTR 32'hA000_0000
`define CRP_ACC_THREE_QTR 31'h6000_0000

`endif

/* crp_pkg.sv */
`default_nettype none

package crp_pkg;

    typedef struct packed {
        logic [6:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } crp_bus_req_t;

    typedef struct packed {
        logic step;
        logic dir;
        logic reached;
    } crp_motor_t;

endpackage : crp_pkg

`default_nettype wire

/* crp_core.sv */
// Operation
// - Without zero-on-arrival, reaching the target ends the ramp until a target or mode write.
// - Zero-on-arrival clears position at target and restarts while target nonzero.
// - Zero-on-arrival clears position whenever it equals target, even after changes.
// - Target may be rewritten during repetition; new target is used next.
// - Circular mode loads the opposite limit when a limit is overstepped.
// - Half-span is write-only; zero span leaves circular mode without effect.
// - Wrap-enable bit in reference config turns circular wrapping on.
// - Range is minus span to span-1; forward from span-1 gives minus span.
// - Backward from minus span gives span-1.
// - Circular positioning takes the shorter direction, across the wrap if shorter.
// - Extension register holds one integer bit and 31 fraction bits.
// - Each wrap adds the extension fraction into an internal accumulator.
// - Accumulator overflow holds position at the wrap for one extra step.
// - Average steps per revolution are twice span plus extension over 2^31.
// - Extension 0x80000000 gives one held step every revolution.
// - Extension 0x40000000 gives one held step every second revolution.
// - Extension 0xA0000000 gives one hold per revolution, two every fourth.
// - Revolution counter counts up on forward wrap, down on backward wrap.
// - Circular mode off clears the revolution counter.
//
// Local design decision: strobed register access.
`include "crp_params.svh"
`default_nettype none

module crp_core #(
    parameter int STEP_DIV = `CRP_STEP_DIV
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire crp_pkg::crp_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    output crp_pkg::crp_motor_t motor_o
);
    import crp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic show_revs;
        logic zero_arr;
        logic circ;
        logic [2:0] mode;
        logic [31:0] span;
        logic [31:0] ext;
        logic [31:0] target;
        logic [31:0] pos;
        logic [31:0] revs;
        logic [30:0] acc;
        logic [1:0] hold;
        logic active;
        logic [15:0] div;
        logic step;
        logic dir;
        logic reached;
        logic [31:0] rdata;
    } crp_state_t;

    localparam logic [15:0] DIV_LAST = 16'(STEP_DIV - 1);

    crp_state_t s_q;
    crp_state_t s_d;

    logic tick;
    logic positioning;
    logic wrap_on;
    logic at_target;
    logic fwd;
    logic [31:0] span_top;
    logic [31:0] span_bot;
    logic signed [32:0] diff;
    logic [32:0] adiff;
    logic [31:0] acc_sum;
    logic stepping;
    logic wrap_fwd;
    logic wrap_bwd;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    assign tick = (s_q.div == DIV_LAST);
    assign positioning = s_q.mode[`CRP_MODE_POS];
    assign wrap_on = s_q.circ && (s_q.span != 32'h0000_0000);
    assign at_target = (s_q.pos == s_q.target);
    assign span_top = s_q.span - 32'h0000_0001;
    assign span_bot = 32'h0000_0000 - s_q.span;
    assign diff = $signed({s_q.target[31], s_q.target}) - $signed({s_q.pos[31], s_q.pos});
    assign adiff = diff[32] ? 33'(-diff) : 33'(diff);
    assign acc_sum = {1'b0, s_q.acc} + {1'b0, s_q.ext[30:0]};
    assign stepping = positioning && s_q.active && tick && (s_q.hold == 2'h0) && !at_target;
    assign wrap_fwd = stepping && wrap_on && fwd && (s_q.pos == span_top);
    assign wrap_bwd = stepping && wrap_on && !fwd && (s_q.pos == span_bot);

    // Direction choice
    always_comb
    begin
        if (wrap_on)
        begin
            if (!diff[32])
            begin
                fwd = (adiff <= {1'b0, s_q.span});
            end
            else
            begin
                fwd = (adiff > {1'b0, s_q.span});
            end
        end
        else
        begin
            fwd = !diff[32];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_d = s_q;
        s_d.step = 1'b0;
        s_d.rdata = `CRP_RST_WORD;
        s_d.div = tick ? 16'h0000 : s_q.div + 16'h0001;

        if (positioning && s_q.active && tick)
        begin
            if (s_q.hold != 2'h0)
            begin
                s_d.hold = s_q.hold - 2'h1;
                s_d.step = 1'b1;
            end
            else if (!at_target)
            begin
                s_d.dir = fwd;
                s_d.step = 1'b1;
                if (wrap_fwd)
                begin
                    s_d.pos = span_bot;
                    s_d.revs = s_q.revs + 32'h0000_0001;
                end
                else if (wrap_bwd)
                begin
                    s_d.pos = span_top;
                    s_d.revs = s_q.revs - 32'h0000_0001;
                end
                else if (fwd)
                begin
                    s_d.pos = s_q.pos + 32'h0000_0001;
                end
                else
                begin
                    s_d.pos = s_q.pos - 32'h0000_0001;
                end
                if (wrap_fwd || wrap_bwd)
                begin
                    s_d.acc = acc_sum[30:0];
                    s_d.hold = {1'b0, s_q.ext[`CRP_EXT_INT]} + {1'b0, acc_sum[31]};
                end
            end
            else if (!s_q.zero_arr || (s_q.target == 32'h0000_0000))
            begin
                s_d.active = 1'b0;
            end
        end

        if (positioning && s_q.zero_arr && at_target)
        begin
            s_d.pos = 32'h0000_0000;
            if (s_q.target != 32'h0000_0000)
            begin
                s_d.active = 1'b1;
            end
        end

        if (!s_q.circ)
        begin
            s_d.revs = 32'h0000_0000;
            s_d.acc = 31'h0000_0000;
        end

        if (bus_i.we)
        begin
            if (bus_i.addr == `CRP_ADDR_GEN_CFG)
            begin
                s_d.show_revs = bus_i.wdata[`CRP_GEN_SHOW_REVS];
            end
            else if (bus_i.addr == `CRP_ADDR_REF_CFG)
            begin
                s_d.zero_arr = bus_i.wdata[`CRP_REF_ZERO_ARR];
                s_d.circ = bus_i.wdata[`CRP_REF_CIRC];
            end
            else if (bus_i.addr == `CRP_ADDR_MODE)
            begin
                s_d.mode = bus_i.wdata[2:0];
                s_d.active = bus_i.wdata[`CRP_MODE_POS];
            end
            else if (bus_i.addr == `CRP_ADDR_ACTUAL)
            begin
                s_d.pos = bus_i.wdata;
            end
            else if (bus_i.addr == `CRP_ADDR_SPAN)
            begin
                s_d.span = bus_i.wdata;
            end
            else if (bus_i.addr == `CRP_ADDR_TARGET)
            begin
                s_d.target = bus_i.wdata;
                s_d.active = 1'b1;
            end
            else if (bus_i.addr == `CRP_ADDR_EXT)
            begin
                s_d.ext = bus_i.wdata;
            end
        end

        if (bus_i.re)
        begin
            if (bus_i.addr == `CRP_ADDR_GEN_CFG)
            begin
                s_d.rdata = {31'h0000_0000, s_q.show_revs};
            end
            else if (bus_i.addr == `CRP_ADDR_REF_CFG)
            begin
                s_d.rdata = {30'h0000_0000, s_q.circ, s_q.zero_arr};
            end
            else if (bus_i.addr == `CRP_ADDR_MODE)
            begin
                s_d.rdata = {29'h0000_0000, s_q.mode};
            end
            else if (bus_i.addr == `CRP_ADDR_ACTUAL)
            begin
                s_d.rdata = s_q.pos;
            end
            else if (bus_i.addr == `CRP_ADDR_STATUS)
            begin
                s_d.rdata = {28'h000_0000, s_q.hold, s_q.active, s_q.reached};
            end
            else if (bus_i.addr == `CRP_ADDR_SPAN)
            begin
                s_d.rdata = s_q.show_revs ? s_q.revs : `CRP_RST_WORD;
            end
            else if (bus_i.addr == `CRP_ADDR_TARGET)
            begin
                s_d.rdata = s_q.target;
            end
            else if (bus_i.addr == `CRP_ADDR_EXT)
            begin
                s_d.rdata = s_q.ext;
            end
        end

        s_d.reached = (s_d.pos == s_d.target);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign motor_o.step = s_q.step;
    assign motor_o.dir = s_q.dir;
    assign motor_o.reached = s_q.reached;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic no_wr;
    assign no_wr = !bus_i.we;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_ramp_end_stop: assert property (
        positioning && s_q.active && tick && s_q.hold == 2'h0 && at_target
        && !s_q.zero_arr && no_wr |=> !s_q.active)
        else $error("ramp not ended at target");

    a_arrive_zero: assert property (
        positioning && s_q.zero_arr && at_target && s_q.target != 32'h0000_0000
        && no_wr |=> s_q.pos == 32'h0000_0000 && s_q.active)
        else $error("no zero and restart on arrival");

    a_fwd_wrap_pos: assert property (
        wrap_fwd && no_wr |=> $signed(s_q.pos) == -$signed($past(s_q.span)))
        else $error("forward wrap wrong");

    a_bwd_wrap_pos: assert property (
        wrap_bwd && no_wr |=> s_q.pos == $past(s_q.span) - 32'h0000_0001)
        else $error("backward wrap wrong");

    a_rev_count_up: assert property (
        wrap_fwd && s_q.circ |=> s_q.revs == $past(s_q.revs) + 32'h0000_0001)
        else $error("revolution count not raised");

    a_rev_cleared: assert property (
        !s_q.circ |=> s_q.revs == 32'h0000_0000)
        else $error("revolution count not cleared");

    a_full_ext_hold: assert property (
        (wrap_fwd || wrap_bwd) && s_q.ext == `CRP_EXT_ONE |=> s_q.hold == 2'h1)
        else $error("no held step for full extension");

    a_half_ext_pair: assert property (
        (wrap_fwd || wrap_bwd) && s_q.ext == `CRP_EXT_HALF && s_q.acc == 31'h0000_0000
        |=> s_q.hold == 2'h0 && s_q.acc == 31'h4000_0000)
        else $error("half extension accumulated wrong");

    a_hold_keeps_pos: assert property (
        positioning && s_q.active && tick && s_q.hold != 2'h0 && no_wr
        && !(s_q.zero_arr && at_target) |=> $stable(s_q.pos) && s_q.step)
        else $error("held step moved position");

    a_short_path: assert property (
        stepping && wrap_on && no_wr && adiff < {1'b0, s_q.span}
        |=> s_q.dir == !$past(diff[32]))
        else $error("longer path taken");

    a_rev_count_down: assert property (
        wrap_bwd && s_q.circ |=> s_q.revs == $past(s_q.revs) - 32'h0000_0001)
        else $error("revolution count not lowered");

    a_acc_adds_ext: assert property (
        (wrap_fwd || wrap_bwd) |=> s_q.acc == 31'($past(s_q.acc) + $past(s_q.ext[30:0])))
        else $error("accumulator not advanced on wrap");

    a_int_bit_hold: assert property (
        (wrap_fwd || wrap_bwd) && s_q.ext[`CRP_EXT_INT] |=> s_q.hold != 2'h0)
        else $error("integer bit gave no held step");

    a_five_qtr_pair: assert property (
        (wrap_fwd || wrap_bwd) && s_q.ext == `CRP_EXT_FIVE_QTR
        && s_q.acc == `CRP_ACC_THREE_QTR |=> s_q.hold == 2'h2)
        else $error("no second held step on carry");

    a_hold_countdown: assert property (
        positioning && s_q.active && tick && s_q.hold != 2'h0
        |=> s_q.hold == $past(s_q.hold) - 2'h1)
        else $error("held step count not consumed");

    a_zero_any_target: assert property (
        positioning && s_q.zero_arr && at_target && no_wr |=> s_q.pos == 32'h0000_0000)
        else $error("position not cleared at target");

    a_done_no_step: assert property (
        positioning && !s_q.active |=> !s_q.step)
        else $error("step after ramp ended");

    a_span_zero_off: assert property (
        s_q.span == 32'h0000_0000 |-> !wrap_fwd && !wrap_bwd)
        else $error("wrap with zero half span");

    a_new_target: assert property (
        bus_i.we && bus_i.addr == `CRP_ADDR_TARGET
        |=> s_q.target == $past(bus_i.wdata) && s_q.active)
        else $error("new target not taken");

    a_acc_cleared: assert property (
        !s_q.circ |=> s_q.acc == 31'h0000_0000)
        else $error("accumulator not cleared");

    c_fwd_wrap: cover property (wrap_fwd);
    c_bwd_wrap: cover property (wrap_bwd);
    c_double_hold: cover property (s_q.hold == 2'h2);
    c_repeat: cover property (s_q.zero_arr && at_target && s_q.active);

endmodule : crp_core

`default_nettype wire

/* crp_motor_model.sv */
`default_nettype none

module crp_motor_model (
    input wire logic ref_clk_i,
    input wire crp_pkg::crp_motor_t motor_i,
    output int pulses_o,
    output int pos_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import crp_pkg::*;

    int pulses_q = 0;
    int pos_q = 0;

    assign pulses_o = pulses_q;
    assign pos_o = pos_q;

    ////////////////////////////////////////////////////////////////////////////
    // Driver side: counts every step pulse and follows direction
    always @(posedge ref_clk_i)
    begin
        if (motor_i.step === 1'b1)
        begin
            pulses_q <= pulses_q + 1;
            pos_q <= (motor_i.dir === 1'b1) ? pos_q + 1 : pos_q - 1;
        end
    end
endmodule : crp_motor_model

`default_nettype wire

/* test_circular_repetitive_position.sv */
`include "crp_params.svh"
`default_nettype none

module test_circular_repetitive_position;
    timeunit 1ns;
    timeprecision 1ps;
    import crp_pkg::*;

    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    crp_bus_req_t bus_q = '0;
    logic [31:0] rdata;
    crp_motor_t motor;
    int pulses;
    int pos;
    int miscompares = 0;
    int comparisons = 0;
    int p0 = 0;
    logic [31:0] d;
    logic [6:0] rst_addr [6] = '{7'h01, 7'h21, 7'h36, 7'h7C, 7'h10, 7'h22};
    logic [31:0] rst_exp [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    logic [31:0] exts [3] = '{32'h8000_0000, 32'h4000_0000, 32'hA000_0000};
    int holds [3][4] = '{'{1, 1, 1, 1}, '{0, 1, 0, 1}, '{1, 1, 1, 2}};

    always #2.5 ref_clk_i = ~ref_clk_i;

    crp_core #(.STEP_DIV(2)) dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bus_i(bus_q),
        .rdata_o(rdata), .motor_o(motor));

    crp_motor_model mdl_u (.ref_clk_i(ref_clk_i), .motor_i(motor), .pulses_o(pulses), .pos_o(pos));

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks and checks
    task automatic close_out();
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        bus_q <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge ref_clk_i);
        bus_q.we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a);
        @(posedge ref_clk_i);
        bus_q <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge ref_clk_i);
        bus_q.re <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic move(input logic [31:0] a, input logic [31:0] t);
        wr(`CRP_ADDR_ACTUAL, a);
        p0 = pulses;
        wr(`CRP_ADDR_TARGET, t);
        for (int i = 0; i < 400; i++)
        begin
            rd(`CRP_ADDR_STATUS);
            if (d[1] === 1'b0)
                break;
            if (i == 399)
            begin
                miscompares++;
                close_out();
            end
        end
        repeat (4) @(posedge ref_clk_i);
    endtask : move

    ////////////////////////////////////////////////////////////////////////////
    // Sequence
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        foreach (rst_addr[i])
        begin
            rd(rst_addr[i]);
            chk("reset_value", rst_exp[i], d);
        end
        wr(`CRP_ADDR_MODE, 32'h4);
        move(32'h0, 32'h3);
        repeat (40) @(posedge ref_clk_i);
        chk("single_steps", 32'h3, pulses - p0);
        chk("motor_pos", 32'h3, pos);
        chk("reached", 32'h1, 32'(motor.reached));
        rd(`CRP_ADDR_ACTUAL);
        chk("actual", 32'h3, d);
        wr(`CRP_ADDR_REF_CFG, 32'h1);
        p0 = pulses;
        wr(`CRP_ADDR_TARGET, 32'h2);
        repeat (80) @(posedge ref_clk_i);
        chk("repeating", 32'h1, 32'(pulses - p0 > 8));
        wr(`CRP_ADDR_TARGET, 32'h1);
        repeat (30) @(posedge ref_clk_i);
        rd(`CRP_ADDR_ACTUAL);
        chk("new_target", 32'h1, 32'(d <= 32'h1));
        wr(`CRP_ADDR_REF_CFG, 32'h0);
        wr(`CRP_ADDR_SPAN, 32'h4);
        move(32'h2, 32'h2);
        wr(`CRP_ADDR_REF_CFG, 32'h2);
        wr(`CRP_ADDR_GEN_CFG, 32'h1);
        move(32'h2, 32'hFFFF_FFFD);
        chk("fwd_steps", 32'h3, pulses - p0);
        chk("fwd_dir", 32'h1, 32'(motor.dir));
        rd(`CRP_ADDR_ACTUAL);
        chk("fwd_pos", 32'hFFFF_FFFD, d);
        rd(`CRP_ADDR_SPAN);
        chk("revs_up", 32'h1, d);
        move(32'hFFFF_FFFD, 32'h2);
        chk("back_steps", 32'h3, pulses - p0);
        chk("back_dir", 32'h0, 32'(motor.dir));
        rd(`CRP_ADDR_SPAN);
        chk("revs_down", 32'h0, d);
        for (int e = 0; e < 3; e++)
        begin
            wr(`CRP_ADDR_REF_CFG, 32'h0);
            rd(`CRP_ADDR_SPAN);
            chk("revs_off", 32'h0, d);
            wr(`CRP_ADDR_EXT, exts[e]);
            rd(`CRP_ADDR_EXT);
            chk("ext", exts[e], d);
            wr(`CRP_ADDR_REF_CFG, 32'h2);
            for (int r = 0; r < 4; r++)
            begin
                move(32'h2, 32'hFFFF_FFFD);
                chk("rev_steps", 3 + holds[e][r], pulses - p0);
            end
        end
        close_out();
    end
endmodule : test_circular_repetitive_position

`default_nettype wire
